// [rtl/sgc_pkg.sv]
// Shared constants, field positions and carrier types for the general control register bank.
// Assumes an 8-bit register space addressed by a serial front end (I2C or SPI).
package sgc_pkg;

    // Register addresses in the full 8-bit (I2C) space
    localparam logic [7:0] SGC_ADDR_HUM_CTRL = 8'h72;
    localparam logic [7:0] SGC_ADDR_PAGE_STAT = 8'h73;
    localparam logic [7:0] SGC_ADDR_MEAS_CTRL = 8'h74;
    localparam logic [7:0] SGC_ADDR_IF_CFG = 8'h75;
    localparam logic [7:0] SGC_ADDR_PART_ID = 8'hD0;
    localparam logic [7:0] SGC_ADDR_SOFT_RST = 8'hE0;

    // SPI carries 7 address bits; the inverted page bit supplies bit 7
    localparam int SGC_SPI_ADDR_W = 7;
    localparam int SGC_ADDR_MSB = 7;

    // Field positions
    localparam int SGC_HUM_IRQ_EN_BIT = 6;
    localparam int SGC_HUM_OSR_LSB = 0;
    localparam int SGC_PAGE_BIT = 4;
    localparam int SGC_MEAS_MODE_LSB = 0;
    localparam int SGC_MEAS_PRS_LSB = 2;
    localparam int SGC_MEAS_TMP_LSB = 5;
    localparam int SGC_CFG_3W_BIT = 0;

    // Implemented-bit masks; unimplemented bits read zero
    localparam logic [7:0] SGC_MASK_HUM_CTRL = 8'h47;
    localparam logic [7:0] SGC_MASK_PAGE_STAT = 8'h10;
    localparam logic [7:0] SGC_MASK_MEAS_CTRL = 8'hFF;
    localparam logic [7:0] SGC_MASK_IF_CFG = 8'h1D;

    // Reset values
    localparam logic [7:0] SGC_RST_REG = 8'h00;
    localparam logic [7:0] SGC_SOFT_RST_KEY = 8'hB6;
    localparam logic [7:0] SGC_READ_ZERO = 8'h00;

    // Value a skipped measurement channel must present
    localparam logic [15:0] SGC_SKIP_FILL = 16'h8000;

    // Oversampling field codes
    localparam logic [2:0] SGC_OSR_SKIP = 3'h0;
    localparam logic [2:0] SGC_OSR_X16_MIN = 3'h5;
    localparam logic [2:0] SGC_OSR_LOG2_MAX = 3'h4;
    localparam logic [2:0] SGC_OSR_ONE = 3'h1;

    typedef enum logic [1:0] {
        SGC_MODE_SLEEP = 2'b00,
        SGC_MODE_FORCED = 2'b01
    } sgc_mode_t;

    // Decoded oversampling of one channel
    typedef struct packed {
        logic skip;
        logic [2:0] log2_ratio;
    } sgc_osr_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] hum_ctrl;
        logic [7:0] page_stat;
        logic [7:0] meas_ctrl;
        logic [7:0] if_cfg;
        logic [7:0] rdata;
        logic rvalid;
        logic soft_rst_pulse;
        logic three_wire;
        logic sleep_mode;
        logic forced_mode;
        sgc_osr_t osr_hum;
        sgc_osr_t osr_tmp;
        sgc_osr_t osr_prs;
        logic sdo_irq;
        logic sdo_irq_oe;
    } sgc_state_t;

endpackage

// [rtl/sgc_regs.sv]
// General control register bank: page, mode, oversampling, three-wire, soft reset, part id.
// Assumes a serial front end that hands over decoded single-cycle register reads and writes.
// Function
// - New-data interrupt needs three-wire and enable bit
// - Interrupt appears on serial data output pad
// - Config bit 0 selects three-wire SPI
// - Mode field: 00 sleep, 01 forced
// - Page bit resets to zero, upper half
// - Page bit one maps SPI onto lower half
// - Page bit in 0x73, reachable both pages
// - Writing 0xB6 to reset register resets all
// - Reset register holds and reads 0x00
// - Reset register at 0x60 SPI, 0xE0 I2C
// - Read-only part identifier at 0x50 / 0xD0
// - Humidity oversampling decode with skip at 000
// - Temperature oversampling decode with skip at 000
// - Pressure oversampling decode with skip at 000
// - Eight-bit registers; SPI seven-bit address plus page
`timescale 1ns/1ns
`default_nettype none

module sgc_regs
    import sgc_pkg::*;
#(
    // Arbitrary neutral value
    parameter logic [7:0] PART_ID = 8'h5A
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_is_spi,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic new_data_event,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic soft_reset_pulse,
    output logic three_wire_select,
    output logic sleep_mode,
    output logic forced_mode,
    output sgc_osr_t osr_humidity,
    output sgc_osr_t osr_temperature,
    output sgc_osr_t osr_pressure,
    output logic sdo_irq_out,
    output logic sdo_irq_oe
);

    sgc_state_t st_r;
    sgc_state_t st_nxt;

    // Oversampling field to skip flag and log2 of the ratio
    function automatic sgc_osr_t osr_decode(input logic [2:0] code);
        sgc_osr_t d;
        d.skip = (code == SGC_OSR_SKIP);
        if (code == SGC_OSR_SKIP) begin
            d.log2_ratio = SGC_OSR_SKIP;
        end else if (code >= SGC_OSR_X16_MIN) begin
            d.log2_ratio = SGC_OSR_LOG2_MAX;
        end else begin
            d.log2_ratio = code - SGC_OSR_ONE;
        end
        return d;
    endfunction

    // Reset image, shared by power-on and soft reset
    function automatic sgc_state_t reset_state();
        sgc_state_t s;
        s = '0;
        s.hum_ctrl = SGC_RST_REG;
        s.page_stat = SGC_RST_REG;
        s.meas_ctrl = SGC_RST_REG;
        s.if_cfg = SGC_RST_REG;
        s.rdata = SGC_READ_ZERO;
        s.sleep_mode = 1'b1;
        s.osr_hum = osr_decode(SGC_OSR_SKIP);
        s.osr_tmp = osr_decode(SGC_OSR_SKIP);
        s.osr_prs = osr_decode(SGC_OSR_SKIP);
        return s;
    endfunction

    logic [7:0] eff_addr;
    logic page_sel;
    logic soft_rst_hit;
    logic [7:0] hum_v;
    logic [7:0] meas_v;
    logic [7:0] cfg_v;
    logic irq_armed;

    always_comb begin
        page_sel = st_r.page_stat[SGC_PAGE_BIT];
        eff_addr = reg_addr;
        if (reg_is_spi) begin
            // Page 0 maps to 0x80..0xFF, page 1 to 0x00..0x7F
            eff_addr = {~page_sel, reg_addr[SGC_SPI_ADDR_W-1:0]};
            // Page register answers in both pages
            if ({1'b0, reg_addr[SGC_SPI_ADDR_W-1:0]} == SGC_ADDR_PAGE_STAT) begin
                eff_addr = SGC_ADDR_PAGE_STAT;
            end
        end
        // Over I2C the full address is used as given
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.soft_rst_pulse = 1'b0;
        // Only the key value triggers; any other value is dropped
        soft_rst_hit = reg_wr && (eff_addr == SGC_ADDR_SOFT_RST) && (reg_wdata == SGC_SOFT_RST_KEY);

        if (reg_wr) begin
            if (eff_addr == SGC_ADDR_HUM_CTRL) begin
                st_nxt.hum_ctrl = reg_wdata & SGC_MASK_HUM_CTRL;
            end else if (eff_addr == SGC_ADDR_PAGE_STAT) begin
                st_nxt.page_stat = reg_wdata & SGC_MASK_PAGE_STAT;
            end else if (eff_addr == SGC_ADDR_MEAS_CTRL) begin
                st_nxt.meas_ctrl = reg_wdata & SGC_MASK_MEAS_CTRL;
            end else if (eff_addr == SGC_ADDR_IF_CFG) begin
                st_nxt.if_cfg = reg_wdata & SGC_MASK_IF_CFG;
            end
            // Part id and unmapped addresses ignore writes
        end

        if (reg_rd) begin
            st_nxt.rvalid = 1'b1;
            if (eff_addr == SGC_ADDR_HUM_CTRL) begin
                st_nxt.rdata = st_r.hum_ctrl;
            end else if (eff_addr == SGC_ADDR_PAGE_STAT) begin
                st_nxt.rdata = st_r.page_stat;
            end else if (eff_addr == SGC_ADDR_MEAS_CTRL) begin
                st_nxt.rdata = st_r.meas_ctrl;
            end else if (eff_addr == SGC_ADDR_IF_CFG) begin
                st_nxt.rdata = st_r.if_cfg;
            end else if (eff_addr == SGC_ADDR_PART_ID) begin
                st_nxt.rdata = PART_ID;
            end else if (eff_addr == SGC_ADDR_SOFT_RST) begin
                st_nxt.rdata = SGC_RST_REG;
            end else begin
                // Reserved space reads zero; host must not rely on it
                st_nxt.rdata = SGC_READ_ZERO;
            end
        end

        // Decoded outputs follow the values being committed this cycle
        hum_v = st_nxt.hum_ctrl;
        meas_v = st_nxt.meas_ctrl;
        cfg_v = st_nxt.if_cfg;
        st_nxt.three_wire = cfg_v[SGC_CFG_3W_BIT];
        st_nxt.sleep_mode = (meas_v[SGC_MEAS_MODE_LSB +: 2] == SGC_MODE_SLEEP);
        st_nxt.forced_mode = (meas_v[SGC_MEAS_MODE_LSB +: 2] == SGC_MODE_FORCED);
        st_nxt.osr_hum = osr_decode(hum_v[SGC_HUM_OSR_LSB +: 3]);
        st_nxt.osr_tmp = osr_decode(meas_v[SGC_MEAS_TMP_LSB +: 3]);
        st_nxt.osr_prs = osr_decode(meas_v[SGC_MEAS_PRS_LSB +: 3]);

        // Pad is spare only in three-wire mode, so drive it only then
        irq_armed = cfg_v[SGC_CFG_3W_BIT] && hum_v[SGC_HUM_IRQ_EN_BIT];
        st_nxt.sdo_irq_oe = irq_armed;
        st_nxt.sdo_irq = irq_armed && new_data_event;

        if (soft_rst_hit) begin
            // Same image as power-on, page bit and mode included
            st_nxt = reset_state();
            st_nxt.soft_rst_pulse = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= reset_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign soft_reset_pulse = st_r.soft_rst_pulse;
    assign three_wire_select = st_r.three_wire;
    assign sleep_mode = st_r.sleep_mode;
    assign forced_mode = st_r.forced_mode;
    assign osr_humidity = st_r.osr_hum;
    assign osr_temperature = st_r.osr_tmp;
    assign osr_pressure = st_r.osr_prs;
    assign sdo_irq_out = st_r.sdo_irq;
    assign sdo_irq_oe = st_r.sdo_irq_oe;

endmodule // sgc_regs

`default_nettype wire

// [testbench/sgc_regs_assertions.sv]
// Checker for the control register bank, bound onto sgc_regs.
// Assumes single-cycle strobes as described for the register port.
`timescale 1ns/1ns
`default_nettype none
module sgc_regs_assertions #(
    parameter logic [7:0] PART_ID = 8'h5A
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_is_spi,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic new_data_event,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic soft_reset_pulse,
    input wire logic three_wire_select,
    input wire logic sleep_mode,
    input wire logic sdo_irq_out,
    input wire logic sdo_irq_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic i2w;
    assign i2w = reg_wr & ~reg_is_spi;
    rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
    rd_only_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
    three_wire_a: assert property (i2w && reg_addr == 8'h75 |=> three_wire_select == $past(reg_wdata[0]))
        else $error("three-wire select wrong");
    mode_sleep_a: assert property (i2w && reg_addr == 8'h74 |=> sleep_mode == ($past(reg_wdata[1:0]) == 2'b00))
        else $error("sleep mode wrong");
    irq_oe_a: assert property (sdo_irq_oe |-> three_wire_select) else $error("pad enabled in four-wire");
    irq_cause_a: assert property (sdo_irq_out |-> $past(new_data_event)) else $error("interrupt without event");
    soft_rst_a: assert property (i2w && reg_addr == 8'hE0 && reg_wdata == 8'hB6 |=>
        soft_reset_pulse && sleep_mode && !three_wire_select) else $error("soft reset missing");
    rst_key_a: assert property (soft_reset_pulse |-> $past(reg_wr && reg_wdata == 8'hB6))
        else $error("soft reset without key");
    part_id_a: assert property (reg_rd && !reg_is_spi && reg_addr == 8'hD0 |=> reg_rdata == PART_ID)
        else $error("part identifier wrong");
endmodule // sgc_regs_assertions
`default_nettype wire

// [testbench/sgc_host_model.sv]
// Host side model: issues one register access at a time over the serial front end port.
// Assumes the caller waits for each access to finish before the next.
`timescale 1ns/1ns
`default_nettype none
module sgc_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic reg_is_spi = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00
);
    task automatic acc(input logic w, s, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_is_spi <= s;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Released lines show garbage, not the last value
        reg_addr <= ~a;
        reg_wdata <= ~d;
        q = 8'h00;
        if (!w) begin
            // Answer launched at this edge; look once it has settled
            #1;
            q = reg_rvalid ? reg_rdata : ~reg_rdata;
        end
    endtask
endmodule // sgc_host_model
`default_nettype wire

// [testbench/sgc_regs_tb_top.sv]
// Self-checking bench for sgc_regs against a register mirror.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sgc_regs_tb_top;
    import sgc_pkg::*;
    localparam logic [7:0] ID = 8'hA7; // Arbitrary value
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic new_data_event = 1'b0;
    logic reg_wr, reg_rd, reg_is_spi, reg_rvalid, soft_reset_pulse, three_wire_select;
    logic sleep_mode, forced_mode, sdo_irq_out, sdo_irq_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, mh, mp, mm, mc, q, d;
    sgc_osr_t osr_humidity, osr_temperature, osr_pressure;
    int n_errors = 0;
    int n_tests = 0;
    sgc_regs #(.PART_ID(ID)) sgc_regs_inst (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_is_spi, .reg_addr,
        .reg_wdata, .new_data_event, .reg_rdata, .reg_rvalid, .soft_reset_pulse, .three_wire_select,
        .sleep_mode, .forced_mode, .osr_humidity, .osr_temperature, .osr_pressure, .sdo_irq_out, .sdo_irq_oe);
    sgc_host_model host (.sys_clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_is_spi, .reg_addr, .reg_wdata);
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            n_errors++;
        end
    endtask
    function automatic logic [7:0] osr(logic [2:0] c);
        return c == 3'h0 ? 8'h08 : (c > 3'h4 ? 8'h04 : {5'h00, c - 3'h1});
    endfunction
    function automatic logic [7:0] eff(logic s, logic [7:0] a);
        return !s ? a : (a[6:0] == 7'h73 ? 8'h73 : {~mp[4], a[6:0]});
    endfunction
    task automatic outs;
        chk("three_wire", {7'h00, mc[0]}, {7'h00, three_wire_select});
        chk("mode", {6'h00, mm[1:0] == 2'b00, mm[1:0] == 2'b01}, {6'h00, sleep_mode, forced_mode});
        chk("osr_h", osr(mh[2:0]), {4'h0, osr_humidity});
        chk("osr_t", osr(mm[7:5]), {4'h0, osr_temperature});
        chk("osr_p", osr(mm[4:2]), {4'h0, osr_pressure});
        chk("irq_oe", {7'h00, mc[0] & mh[6]}, {7'h00, sdo_irq_oe});
    endtask
    task automatic wr(logic s, logic [7:0] a, logic [7:0] v);
        logic [7:0] e;
        e = eff(s, a);
        host.acc(1'b1, s, a, v, q);
        #1;
        if (e == 8'h72) mh = v & SGC_MASK_HUM_CTRL;
        if (e == 8'h73) mp = v & SGC_MASK_PAGE_STAT;
        if (e == 8'h74) mm = v;
        if (e == 8'h75) mc = v & SGC_MASK_IF_CFG;
        if (e == 8'hE0 && v == 8'hB6) {mh, mp, mm, mc} = 32'h0000_0000;
        outs;
    endtask
    task automatic rd(logic s, logic [7:0] a);
        logic [7:0] e;
        case (eff(s, a))
            8'h72: e = mh;
            8'h73: e = mp;
            8'h74: e = mm;
            8'h75: e = mc;
            8'hD0: e = ID;
            default: e = 8'h00;
        endcase
        host.acc(1'b0, s, a, 8'h00, q);
        chk("rdata", e, q);
    endtask
    task automatic final_report;
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        final_report;
    end
    initial begin
        void'($urandom(32'h1949));
        {mh, mp, mm, mc} = 32'h0000_0000;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        #1 outs;
        for (int i = 0; i < 8; i++) rd(1'b0, 8'h70 + 8'(i));
        for (int i = 0; i < 24; i++) begin
            d = i < 8 ? {i[2:0], i[2:0], i[1:0]} : 8'($urandom);
            wr(1'b0, 8'h74, d);
            wr(1'b0, 8'h72, d);
            wr(1'b0, 8'h75, ~d);
            rd(1'b0, 8'h72);
            rd(1'b0, 8'h74);
            rd(1'b0, 8'h75);
        end
        wr(1'b0, 8'hD0, 8'h00);
        wr(1'b0, 8'hE0, 8'h5A);
        rd(1'b0, 8'hD0);
        rd(1'b0, 8'hE0);
        rd(1'b1, 8'h50);
        rd(1'b1, 8'h60);
        wr(1'b1, 8'h73, 8'hFF);
        rd(1'b1, 8'h72);
        rd(1'b1, 8'h73);
        rd(1'b0, 8'hD0);
        wr(1'b1, 8'h75, 8'h01);
        wr(1'b1, 8'h72, 8'h40);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk) new_data_event <= 1'b1;
            @(posedge sys_clk) new_data_event <= 1'b0;
            #1 chk("irq", {7'h00, k == 0}, {7'h00, sdo_irq_out});
            wr(1'b1, 8'h75, 8'h00);
        end
        wr(1'b0, 8'hE0, 8'hB6);
        chk("soft_reset", 8'h01, {7'h00, soft_reset_pulse});
        rd(1'b1, 8'h50);
        rd(1'b0, 8'h72);
        final_report;
    end
endmodule // sgc_regs_tb_top
bind sgc_regs sgc_regs_assertions #(.PART_ID(PART_ID)) sgc_regs_assertions_inst (.*);
`default_nettype wire
